// ---- pkg/ssfp_consts.vh ----
// Constants for the synchronous serial port framing block.
// Assumes inclusion by the design file under hw/ and by the checker and bench under verification/.
`ifndef SSFP_CONSTS_VH
`define SSFP_CONSTS_VH

// Register byte offsets on the peripheral bus
`define SSFP_OFF_CTRL_A     8'h00
`define SSFP_OFF_CTRL_B     8'h04
`define SSFP_OFF_IIR        8'h08
`define SSFP_OFF_DATA       8'h0c
`define SSFP_OFF_PRESC      8'h10
`define SSFP_OFF_STAT       8'h14
`define SSFP_OFF_LIMIT      8'h18
// Register reset values
`define SSFP_RST_CTRL_A     16'h0000
`define SSFP_RST_CTRL_B     8'h00
`define SSFP_RST_PRESC      8'h02
// Writable bits of control word A (bit 6 reads zero)
`define SSFP_CTRL_A_WMASK   16'hffbf
// Control word A fields
`define SSFP_A_SCR_HI       15
`define SSFP_A_SCR_LO       8
`define SSFP_A_SSE          7
`define SSFP_A_FRF_HI       5
`define SSFP_A_FRF_LO       4
`define SSFP_A_DSS_HI       3
`define SSFP_A_DSS_LO       0
// Control word B fields
`define SSFP_B_POL          3
`define SSFP_B_PHA          4
// Frame format codes
`define SSFP_FRF_SPI        2'b00
`define SSFP_FRF_PULSED     2'b01
`define SSFP_FRF_HALFDUP    2'b10
// Last index of the half-duplex command byte
`define SSFP_CMD_LAST       4'h7
// Highest word length code
`define SSFP_DSS_MAX        4'hf
// Transmit queue geometry
`define SSFP_FIFO_DEPTH     5'h08
`define SSFP_FIFO_AW        3
// Status register bit positions
`define SSFP_ST_TFE         0
`define SSFP_ST_TNF         1
`define SSFP_ST_RNE         2
`define SSFP_ST_BSY         3
`define SSFP_ST_ROR         4

`endif

// ---- hw/ssfp_port.v ----
// Synchronous serial port framing block: APB register file, transmit
// queue, receive holding word and the serial frame engine.
// Assumes APB3 master on core_clk_in, inputs synchronous to that clock.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ssfp_consts.vh"

module ssfp_port (
	input  wire        core_clk_in,        // System clock
	input  wire        rst_b_in,           // Synchronous reset, active low
	input  wire        ce_in,              // Clock enable, freezes state when low
	input  wire        psel_in,            // APB select
	input  wire        penable_in,         // APB enable
	input  wire        pwrite_in,          // APB direction
	input  wire [7:0]  paddr_in,           // APB byte address
	input  wire [31:0] pwdata_in,          // APB write data
	output wire [31:0] prdata_out,         // APB read data
	output wire        pready_out,         // APB ready
	output wire        pslverr_out,        // APB error, unmapped address
	input  wire        serial_data_in,     // Line data from the slave
	output wire        serial_data_out,    // Line data to the slave
	output wire        serial_clock_out,   // Serial clock
	output wire        frame_pulse_out,    // Pulsed-format sync, active high
	output wire        frame_select_n_out  // Frame select, active low
);

	////////////////////////////////////////////////////////////////////////
	// Engine states, one-hot
	localparam [5:0] ST_IDLE  = 6'h01;     // Waiting for a queued word
	localparam [5:0] ST_SYNC  = 6'h02;     // Sync pulse period
	localparam [5:0] ST_SHIFT = 6'h04;     // Data or command bits
	localparam [5:0] ST_TURN  = 6'h08;     // Turnaround period
	localparam [5:0] ST_REPLY = 6'h10;     // Reply bits
	localparam [5:0] ST_END   = 6'h20;     // Half period of rest

	////////////////////////////////////////////////////////////////////////
	// Registers
	reg  [15:0] ctrl_a_reg;                // Control word A
	reg  [7:0]  ctrl_b_reg;                // Control word B
	reg  [7:0]  presc_reg;                 // Prescale divider
	reg  [31:0] prdata_reg;                // Read data
	reg         pready_reg;                // Ready
	reg         pslverr_reg;               // Error
	reg  [15:0] tx_mem [0:7];              // Transmit queue storage
	reg  [2:0]  wr_ptr_reg;                // Queue write index
	reg  [2:0]  rd_ptr_reg;                // Queue read index
	reg  [4:0]  fifo_cnt_reg;              // Queue fill level
	reg  [15:0] rx_hold_reg;               // Received word
	reg         rx_full_reg;               // Received word waiting
	reg         overrun_reg;               // Received word lost
	reg  [5:0]  state_reg;                 // Engine state
	reg         half_reg;                  // Second half of a bit period
	reg  [3:0]  bit_cnt_reg;               // Bit index within segment
	reg  [15:0] tx_sh_reg;                 // Transmit shifter
	reg  [15:0] rx_sh_reg;                 // Receive shifter
	reg  [7:0]  pre_cnt_reg;               // Prescale counter
	reg  [7:0]  scr_cnt_reg;               // Rate divisor counter
	reg         sclk_reg;                  // Serial clock flop
	reg         sdo_reg;                   // Serial data flop
	reg         pulse_reg;                 // Sync pulse flop
	reg         fsn_reg;                   // Frame select flop

	////////////////////////////////////////////////////////////////////////
	// Field decode
	// field extraction
	wire [7:0]  scr_w   = ctrl_a_reg[`SSFP_A_SCR_HI:`SSFP_A_SCR_LO];
	wire        sse_w   = ctrl_a_reg[`SSFP_A_SSE];
	wire [1:0]  frf_w   = ctrl_a_reg[`SSFP_A_FRF_HI:`SSFP_A_FRF_LO];
	wire [3:0]  dss_w   = ctrl_a_reg[`SSFP_A_DSS_HI:`SSFP_A_DSS_LO];
	wire        pol_w   = ctrl_b_reg[`SSFP_B_POL];
	wire        pha_w   = ctrl_b_reg[`SSFP_B_PHA];
	wire        is_pul_w = (frf_w == `SSFP_FRF_PULSED);
	wire        is_hd_w  = (frf_w == `SSFP_FRF_HALFDUP);
	wire        is_spi_w = (frf_w == `SSFP_FRF_SPI);
	// Active-first bits: clock leaves idle at the start of each period.
	// Pulsed keeps its launch edge rising, half-duplex its capture edge
	// rising, whatever the idle level.
	// edge choice per format
	wire        act_first_w = (is_pul_w & ~pol_w) | (is_hd_w & pol_w) | (is_spi_w & pha_w);

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire        acc_w    = psel_in & penable_in & pready_reg;
	wire        wr_w     = acc_w & pwrite_in;
	wire        rd_w     = acc_w & ~pwrite_in;
	wire        mapped_w = (paddr_in < `SSFP_OFF_LIMIT) && (paddr_in[1:0] == 2'b00);
	wire        fifo_full_w  = (fifo_cnt_reg == `SSFP_FIFO_DEPTH);
	wire        fifo_empty_w = (fifo_cnt_reg == 5'h00);
	wire        push_w   = wr_w & (paddr_in == `SSFP_OFF_DATA) & ~fifo_full_w;
	wire        rd_dat_w = rd_w & (paddr_in == `SSFP_OFF_DATA);
	wire        ovr_clr_w = wr_w & (paddr_in == `SSFP_OFF_IIR);

	////////////////////////////////////////////////////////////////////////
	// Bit clock generation
	// half-period tick from prescaler and rate divisor
	wire        pre_done_w = (({1'b0, pre_cnt_reg} + 9'h001) >= {1'b0, presc_reg});
	wire        tick_w     = pre_done_w & (scr_cnt_reg == scr_w);
	wire        idle_w     = (state_reg == ST_IDLE);
	wire        start_w    = idle_w & sse_w & ~fifo_empty_w;
	wire [3:0]  last_w     = (is_hd_w && state_reg == ST_SHIFT) ? `SSFP_CMD_LAST : dss_w;
	wire        bit_end_w  = tick_w & half_reg & (bit_cnt_reg == last_w) &
	                         ((state_reg == ST_SHIFT) | (state_reg == ST_REPLY));
	wire        store_w    = bit_end_w & ((state_reg == ST_REPLY) | ~is_hd_w);
	wire [15:0] head_w     = tx_mem[rd_ptr_reg];
	// left-align the word so its MSB leaves first
	wire [3:0]  lsh_w      = `SSFP_DSS_MAX - dss_w;
	wire [15:0] load_w     = is_hd_w ? {head_w[7:0], 8'h00} : (head_w << lsh_w);

	////////////////////////////////////////////////////////////////////////
	// APB slave and control registers
	always @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			ctrl_a_reg  <= `SSFP_RST_CTRL_A;
			ctrl_b_reg  <= `SSFP_RST_CTRL_B;
			presc_reg   <= `SSFP_RST_PRESC;
			prdata_reg  <= 32'h0000_0000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else if (ce_in) begin
			// One wait cycle, then ready for one cycle
			pready_reg  <= psel_in & penable_in & ~pready_reg;
			if (psel_in && penable_in && !pready_reg) begin
				pslverr_reg <= ~mapped_w;
				// Read mux
				case (paddr_in)
					`SSFP_OFF_CTRL_A: prdata_reg <= {16'h0000, ctrl_a_reg};
					`SSFP_OFF_CTRL_B: prdata_reg <= {24'h000000, ctrl_b_reg};
					`SSFP_OFF_DATA:   prdata_reg <= {16'h0000, rx_hold_reg};
					`SSFP_OFF_PRESC:  prdata_reg <= {24'h000000, presc_reg};
					`SSFP_OFF_STAT: begin
						prdata_reg <= 32'h0000_0000;
						prdata_reg[`SSFP_ST_TFE] <= fifo_empty_w;
						prdata_reg[`SSFP_ST_TNF] <= ~fifo_full_w;
						prdata_reg[`SSFP_ST_RNE] <= rx_full_reg;
						prdata_reg[`SSFP_ST_BSY] <= ~idle_w | ~fifo_empty_w;
						prdata_reg[`SSFP_ST_ROR] <= overrun_reg;
					end
					// Identification and unmapped read zero
					default:          prdata_reg <= 32'h0000_0000;
				endcase
			end else begin
				pslverr_reg <= 1'b0;
			end
			// writable fields, bit 6 forced zero
			if (wr_w && paddr_in == `SSFP_OFF_CTRL_A) begin
				ctrl_a_reg <= pwdata_in[15:0] & `SSFP_CTRL_A_WMASK;
			end
			if (wr_w && paddr_in == `SSFP_OFF_CTRL_B) begin
				ctrl_b_reg <= pwdata_in[7:0];
			end
			if (wr_w && paddr_in == `SSFP_OFF_PRESC) begin
				presc_reg <= pwdata_in[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit queue storage, no reset needed on data
	always @(posedge core_clk_in) begin
		if (ce_in && push_w) begin
			tx_mem[wr_ptr_reg] <= pwdata_in[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit queue pointers
	// queue feeds the engine until empty
	always @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			wr_ptr_reg   <= 3'h0;
			rd_ptr_reg   <= 3'h0;
			fifo_cnt_reg <= 5'h00;
		end else if (ce_in) begin
			if (push_w) begin
				wr_ptr_reg <= wr_ptr_reg + 3'h1;
			end
			if (start_w) begin
				rd_ptr_reg <= rd_ptr_reg + 3'h1;
			end
			// Level tracks both sides
			if (push_w && !start_w) begin
				fifo_cnt_reg <= fifo_cnt_reg + 5'h01;
			end else if (!push_w && start_w) begin
				fifo_cnt_reg <= fifo_cnt_reg - 5'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive holding word and overrun flag
	always @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			rx_hold_reg <= 16'h0000;
			rx_full_reg <= 1'b0;
			overrun_reg <= 1'b0;
		end else if (ce_in) begin
			if (store_w && (!rx_full_reg || rd_dat_w)) begin
				rx_hold_reg <= rx_sh_reg;
				rx_full_reg <= 1'b1;
			end else if (rd_dat_w) begin
				rx_full_reg <= 1'b0;
			end
			// Set wins over clear
			if (store_w && rx_full_reg && !rd_dat_w) begin
				overrun_reg <= 1'b1;
			end else if (ovr_clr_w) begin
				overrun_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Divider counters, held at zero outside frames
	always @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			pre_cnt_reg <= 8'h00;
			scr_cnt_reg <= 8'h00;
		end else if (ce_in) begin
			if (idle_w) begin
				pre_cnt_reg <= 8'h00;
				scr_cnt_reg <= 8'h00;
			end else if (pre_done_w) begin
				pre_cnt_reg <= 8'h00;
				scr_cnt_reg <= (scr_cnt_reg == scr_w) ? 8'h00 : scr_cnt_reg + 8'h01;
			end else begin
				pre_cnt_reg <= pre_cnt_reg + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame engine
	always @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			state_reg   <= ST_IDLE;
			half_reg    <= 1'b0;
			bit_cnt_reg <= 4'h0;
			tx_sh_reg   <= 16'h0000;
			rx_sh_reg   <= 16'h0000;
			sclk_reg    <= 1'b0;
			sdo_reg     <= 1'b0;
			pulse_reg   <= 1'b0;
			fsn_reg     <= 1'b1;
		end else if (ce_in) begin
			case (state_reg)
				ST_IDLE: begin
					// clock rests at the polarity level
					sclk_reg  <= pol_w;
					sdo_reg   <= 1'b0;
					pulse_reg <= 1'b0;
					fsn_reg   <= 1'b1;
					half_reg  <= 1'b0;
					if (start_w) begin
						tx_sh_reg   <= load_w;
						rx_sh_reg   <= 16'h0000;
						bit_cnt_reg <= 4'h0;
						sclk_reg    <= act_first_w ? ~pol_w : pol_w;
						if (is_pul_w) begin
							state_reg <= ST_SYNC;
							pulse_reg <= 1'b1;
						end else begin
							// select goes low for the frame
							state_reg <= ST_SHIFT;
							fsn_reg   <= 1'b0;
							sdo_reg   <= load_w[15];
						end
					end
				end
				ST_SYNC: begin
					if (tick_w) begin
						half_reg <= ~half_reg;
						// Pulsed clock is high in the first half of a period
						sclk_reg <= half_reg;
						if (half_reg) begin
							// first bit launched on rising edge
							pulse_reg <= 1'b0;
							state_reg <= ST_SHIFT;
							sdo_reg   <= tx_sh_reg[15];
						end
					end
				end
				ST_SHIFT, ST_TURN, ST_REPLY: begin
					if (!sse_w) begin
						state_reg <= ST_END;
					end else if (tick_w && !half_reg) begin
						// clock moves only on ticks in a frame
						half_reg <= 1'b1;
						sclk_reg <= act_first_w ? pol_w : ~pol_w;
						// capture skipped while command goes out
						if (state_reg == ST_REPLY ||
						    (state_reg == ST_SHIFT && !is_hd_w)) begin
							rx_sh_reg <= {rx_sh_reg[14:0], serial_data_in};
						end
					end else if (tick_w) begin
						half_reg <= 1'b0;
						sclk_reg <= act_first_w ? ~pol_w : pol_w;
						if (state_reg == ST_TURN) begin
							state_reg   <= ST_REPLY;
							bit_cnt_reg <= 4'h0;
						end else if (bit_cnt_reg == last_w) begin
							sdo_reg <= 1'b0;
							// 8 + 1 + reply bits
							if (is_hd_w && state_reg == ST_SHIFT) begin
								state_reg <= ST_TURN;
							end else begin
								state_reg <= ST_END;
								sclk_reg  <= pol_w;
							end
						end else begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							tx_sh_reg   <= {tx_sh_reg[14:0], 1'b0};
							if (state_reg == ST_SHIFT) begin
								sdo_reg <= tx_sh_reg[14];
							end
						end
					end
				end
				ST_END: begin
					// select rises to mark the frame end
					sclk_reg  <= pol_w;
					fsn_reg   <= 1'b1;
					pulse_reg <= 1'b0;
					sdo_reg   <= 1'b0;
					if (tick_w || !sse_w) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from flops
	assign prdata_out         = prdata_reg;
	assign pready_out         = pready_reg;
	assign pslverr_out        = pslverr_reg;
	assign serial_data_out    = sdo_reg;
	assign serial_clock_out   = sclk_reg;
	assign frame_pulse_out    = pulse_reg;
	assign frame_select_n_out = fsn_reg;

endmodule
`default_nettype wire

// ---- verification/ssfp_port_assertions.sv ----
// Checker for the serial port block: bus answer timing and line framing.
// Assumes binding to ssfp_port; control writes are snooped to track settings.
`timescale 1ns/1ps
`default_nettype none
`include "ssfp_consts.vh"
module ssfp_port_chk (
	input wire logic        core_clk_in,
	input wire logic        rst_b_in,
	input wire logic        ce_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [7:0]  paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	input wire logic        serial_clock_out,
	input wire logic        frame_pulse_out,
	input wire logic        frame_select_n_out
);
	////////////////////////////////////////////////////////////////
	logic       pol_q; // Snooped idle polarity
	logic       en_q;  // Snooped port enable
	logic [1:0] fmt_q; // Snooped frame format
	wire        acc = psel_in && penable_in && pready_out; // Completing access
	// Track settings at the edge where a write takes effect
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			pol_q <= 1'b0;
			en_q <= 1'b0;
			fmt_q <= 2'b00;
		end else if (ce_in && acc && pwrite_in && !pslverr_out) begin
			if (paddr_in == `SSFP_OFF_CTRL_A) begin
				en_q <= pwdata_in[`SSFP_A_SSE];
				fmt_q <= pwdata_in[`SSFP_A_FRF_HI:`SSFP_A_FRF_LO];
			end
			if (paddr_in == `SSFP_OFF_CTRL_B) begin
				pol_q <= pwdata_in[`SSFP_B_POL];
			end
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_setup;
		psel_in && !penable_in;
	endsequence
	sequence s_wait;
		!pready_out ##1 pready_out;
	endsequence
	property p_one_wait;
		s_setup |=> s_wait;
	endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("bus answer not after one wait state");
	property p_err_map;
		acc |-> pslverr_out == (paddr_in >= `SSFP_OFF_LIMIT || paddr_in[1:0] != 2'b00);
	endproperty
	a_err_map: assert property (p_err_map)
		else $error("error flag does not match address map");
	property p_rsv_zero;
		acc && !pwrite_in && pslverr_out |-> prdata_out == 32'h0;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero)
		else $error("refused read returned data");
	property p_idle_lvl;
		frame_select_n_out && $past(frame_select_n_out) && fmt_q != `SSFP_FRF_PULSED
			&& pol_q == $past(pol_q, 2) |-> serial_clock_out == pol_q;
	endproperty
	a_idle_lvl: assert property (p_idle_lvl)
		else $error("idle clock level differs from polarity");
	property p_static;
		$changed(serial_clock_out) && fmt_q != `SSFP_FRF_PULSED
			&& pol_q == $past(pol_q, 2) |-> !frame_select_n_out;
	endproperty
	a_static: assert property (p_static)
		else $error("clock moved outside a frame");
	property p_pulse_edge;
		$rose(frame_pulse_out) |-> serial_clock_out;
	endproperty
	a_pulse_edge: assert property (p_pulse_edge)
		else $error("sync pulse not started on active clock edge");
	property p_pulse_fmt;
		frame_pulse_out |-> fmt_q == `SSFP_FRF_PULSED;
	endproperty
	a_pulse_fmt: assert property (p_pulse_fmt)
		else $error("sync pulse outside pulsed format");
	property p_sel_fmt;
		!frame_select_n_out |-> fmt_q != `SSFP_FRF_PULSED;
	endproperty
	a_sel_fmt: assert property (p_sel_fmt)
		else $error("frame select low in pulsed format");
	property p_enable;
		$fell(frame_select_n_out) || $rose(frame_pulse_out) |-> en_q;
	endproperty
	a_enable: assert property (p_enable)
		else $error("frame started while port disabled");
endmodule
bind ssfp_port ssfp_port_chk chk_u (
	.core_clk_in        (core_clk_in),
	.rst_b_in           (rst_b_in),
	.ce_in              (ce_in),
	.psel_in            (psel_in),
	.penable_in         (penable_in),
	.pwrite_in          (pwrite_in),
	.paddr_in           (paddr_in),
	.pwdata_in          (pwdata_in),
	.prdata_out         (prdata_out),
	.pready_out         (pready_out),
	.pslverr_out        (pslverr_out),
	.serial_clock_out   (serial_clock_out),
	.frame_pulse_out    (frame_pulse_out),
	.frame_select_n_out (frame_select_n_out)
);
`default_nettype wire

// ---- verification/ssfp_line_slave.sv ----
// Behavioural serial slave: captures line data, returns a fixed reply word.
// Assumes the bench sets capture level, reply offset and format flag.
`timescale 1ns/1ps
`default_nettype none
module ssfp_line_slave (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        sclk_in,
	input  wire logic        sdo_in,
	input  wire logic        sel_n_in,
	input  wire logic        pulse_in,
	input  wire logic        pulsed_in,
	input  wire logic        cap_lvl_in,
	input  wire logic [3:0]  skip_in,
	input  wire logic [15:0] reply_in,
	output logic             sdi_out,
	output logic [31:0]      cap_out,
	output logic [5:0]       ncap_out
);
	logic        sclk_q; // Clock one cycle ago
	logic        sel_q;  // Select one cycle ago
	logic        pul_q;  // Pulse one cycle ago
	logic        alt_q;  // Changing level when released
	logic [15:0] sh_q;   // Reply shifter, MSB on the line
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			sclk_q <= 1'b0;
			sel_q <= 1'b1;
			pul_q <= 1'b0;
			alt_q <= 1'b0;
			sh_q <= 16'h0;
			cap_out <= 32'h0;
			ncap_out <= 6'h0;
		end else begin
			sclk_q <= sclk_in;
			sel_q <= sel_n_in;
			pul_q <= pulse_in;
			alt_q <= ~alt_q;
			if ((sel_q && !sel_n_in) || (!pul_q && pulse_in)) begin
				ncap_out <= 6'h0;
				sh_q <= reply_in;
			end else if (sclk_in != sclk_q) begin
				if (sclk_in == cap_lvl_in) begin
					cap_out <= {cap_out[30:0], sdo_in};
					ncap_out <= ncap_out + 6'h1;
				end else if (ncap_out > {2'b00, skip_in}) begin
					sh_q <= {sh_q[14:0], ~sh_q[15]};
				end
			end
		end
	end
	assign sdi_out = (!sel_n_in || pulsed_in) ? sh_q[15] : alt_q;
endmodule
`default_nettype wire

// ---- verification/test_sync_serial_port_framing.sv ----
// Bench for the serial port block: registers, all formats, queueing.
// Assumes ssfp_port, the line slave and the checker bound beside it.
`timescale 1ns/1ps
`default_nettype none
`include "ssfp_consts.vh"
module test_sync_serial_port_framing;
	localparam logic [15:0] RPL = 16'hc5a3; // Slave reply word
	logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, cap;
	logic        pready, perr, sdi, sdo, sclk, fpul, fsel_n, lvl = 1'b0, pmode = 1'b0;
	logic [3:0]  skip = 4'h0;
	logic [5:0]  ncap;
	int          n_fail = 0, check_count = 0, cyc = 0;
	always #10 clk = ~clk;
	ssfp_port dut_u (.core_clk_in(clk), .rst_b_in(rst_b), .ce_in(1'b1), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
		.serial_data_in(sdi), .serial_data_out(sdo), .serial_clock_out(sclk),
		.frame_pulse_out(fpul), .frame_select_n_out(fsel_n));
	ssfp_line_slave slv_u (.clk_in(clk), .rst_b_in(rst_b), .sclk_in(sclk), .sdo_in(sdo),
		.sel_n_in(fsel_n), .pulse_in(fpul), .pulsed_in(pmode), .cap_lvl_in(lvl),
		.skip_in(skip), .reply_in(RPL), .sdi_out(sdi), .cap_out(cap), .ncap_out(ncap));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("FAIL %s expected %h seen %h", nm, exp, got);
			n_fail++;
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// One bus transfer, held until ready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, r, exp);
	endtask
	// Poll status until the queue is empty and the line is at rest
	task automatic wait_idle;
		logic [31:0] r;
		logic e;
		forever begin
			apb(1'b0, `SSFP_OFF_STAT, 32'h0, r, e);
			if (r[3] === 1'b0 && r[0] === 1'b1 && fsel_n === 1'b1 && fpul === 1'b0) break;
		end
	endtask
	task automatic cfg(input logic [1:0] f, input logic ph, input logic po, input int len);
		lvl <= (f == `SSFP_FRF_PULSED) ? 1'b0 : (f == `SSFP_FRF_HALFDUP) ? 1'b1 : (ph ? po : ~po);
		skip <= (f == `SSFP_FRF_HALFDUP) ? 4'h9 : {3'b000, f == `SSFP_FRF_PULSED};
		pmode <= (f == `SSFP_FRF_PULSED);
		wr(`SSFP_OFF_CTRL_B, {27'h0, ph, po, 3'b000});
		wr(`SSFP_OFF_CTRL_A, {24'h0, 1'b1, 1'b0, f, 4'(len - 1)});
	endtask
	// Single frame: periods, sent bits, received word, resting clock
	task automatic run(input logic [1:0] f, input logic ph, input logic po, input int len,
		input logic [15:0] tx);
		logic [31:0] m;
		m = (32'h1 << len) - 32'h1;
		cfg(f, ph, po, len);
		wr(`SSFP_OFF_DATA, {16'h0, tx});
		wait_idle();
		chk("periods", {26'h0, ncap}, len + skip);
		if (f == `SSFP_FRF_HALFDUP) chk("command", (cap >> (len + 1)) & 32'hff, {24'h0, tx[7:0]});
		else chk("tx word", cap & m, {16'h0, tx} & m);
		rd(`SSFP_OFF_DATA, {16'h0, RPL} >> (16 - len), "rx word");
		chk("idle clock", {31'h0, sclk}, {31'h0, po});
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [31:0] r;
		logic e;
		rd(`SSFP_OFF_CTRL_A, 32'h0, "ctrl a reset");
		rd(`SSFP_OFF_CTRL_B, 32'h0, "ctrl b reset");
		rd(`SSFP_OFF_PRESC, 32'h2, "prescale reset");
		wr(`SSFP_OFF_PRESC, 32'h5);
		rd(`SSFP_OFF_PRESC, 32'h5, "prescale rw");
		wr(`SSFP_OFF_PRESC, 32'h2);
		wr(`SSFP_OFF_CTRL_A, 32'hffff_ff7f);
		rd(`SSFP_OFF_CTRL_A, 32'h0000_ff3f, "ctrl a fields");
		wr(`SSFP_OFF_CTRL_B, 32'h18);
		rd(`SSFP_OFF_CTRL_B, 32'h18, "ctrl b fields");
		apb(1'b0, `SSFP_OFF_LIMIT, 32'h0, r, e);
		chk("reserved read", {e, r[30:0]}, 32'h8000_0000);
		wr(`SSFP_OFF_CTRL_B, 32'h0);
		wr(`SSFP_OFF_CTRL_A, 32'h0);
		$display("t_regs done");
	endtask
	task automatic t_lengths;
		for (int len = 4; len <= 16; len++) run(`SSFP_FRF_SPI, 1'b0, 1'b0, len, 16'ha5c3 ^ 16'(len));
		$display("t_lengths done");
	endtask
	task automatic t_modes;
		for (int m = 0; m < 4; m++) run(`SSFP_FRF_SPI, m[1], m[0], 8, 16'h5a96);
		$display("t_modes done");
	endtask
	task automatic t_halfdup;
		run(`SSFP_FRF_HALFDUP, 1'b0, 1'b0, 4, 16'hbe5d);
		run(`SSFP_FRF_HALFDUP, 1'b0, 1'b1, 16, 16'h1c27);
		$display("t_halfdup done");
	endtask
	task automatic t_pulsed;
		run(`SSFP_FRF_PULSED, 1'b0, 1'b0, 8, 16'h00e7);
		run(`SSFP_FRF_PULSED, 1'b0, 1'b1, 12, 16'h0b3c);
		$display("t_pulsed done");
	endtask
	task automatic t_cont;
		cfg(`SSFP_FRF_SPI, 1'b0, 1'b0, 8);
		wr(`SSFP_OFF_DATA, 32'h3c);
		wr(`SSFP_OFF_DATA, 32'hd2);
		wr(`SSFP_OFF_DATA, 32'h81);
		wait_idle();
		chk("queued words", cap & 32'hff_ffff, 32'h3c_d281);
		rd(`SSFP_OFF_STAT, 32'h17, "overrun status");
		wr(`SSFP_OFF_IIR, 32'h0);
		rd(`SSFP_OFF_STAT, 32'h07, "overrun cleared");
		rd(`SSFP_OFF_DATA, {24'h0, RPL[15:8]}, "kept word");
		$display("t_cont done");
	endtask
	task automatic t_enable;
		wr(`SSFP_OFF_CTRL_A, 32'h07);
		wr(`SSFP_OFF_DATA, 32'h69);
		rd(`SSFP_OFF_STAT, 32'h0a, "held while disabled");
		chk("select held", {31'h0, fsel_n}, 32'h1);
		wr(`SSFP_OFF_CTRL_A, 32'h87);
		wait_idle();
		chk("sent after enable", cap & 32'hff, 32'h69);
		$display("t_enable done");
	endtask
	////////////////////////////////////////////////////////////////
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_lengths();
		t_modes();
		t_halfdup();
		t_pulsed();
		t_cont();
		t_enable();
		summarize();
	end
endmodule
`default_nettype wire
